//--- src/period_timer_map.svh
// Register offsets, field positions, reset values and timing constants
// of the period timer. Assumes byte addresses on a 32-bit Wishbone bus.
`ifndef PERIOD_TIMER_MAP_SVH
`define PERIOD_TIMER_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_COUNT_VALUE 8'h00
`define OFS_PERIOD_VALUE 8'h04
`define OFS_TIMER_CONTROL 8'h08
`define OFS_MATCH_STATUS 8'h0C

// ************************************************************
// Field positions in timer_control
// ************************************************************
`define CTL_ENABLE 0
`define CTL_PRE_LO 1
`define CTL_PRE_HI 3
`define CTL_POST_LO 4
`define CTL_POST_HI 7
`define CTL_MODE_LO 8
`define CTL_MODE_HI 12
`define CTL_PRESCALE_OUTPUT_SYNC 13
`define CTL_ENABLE_CLOCK_SYNC 14

// ************************************************************
// Field positions in match_status
// ************************************************************
`define STS_FLAG 0
`define STS_IRQ_EN 1
`define STS_RUN 2

// ************************************************************
// Reset values
// ************************************************************
`define RST_COUNT_VALUE 8'h00
`define RST_PERIOD_VALUE 8'hFF
`define RST_PRE_SELECT 3'h0
`define RST_POST_SELECT 4'h0
`define RST_MODE 5'h00

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define WB_ACK_CYCLES 1

`endif

//--- src/period_timer_pkg.sv
// Types shared by the period timer.
// Assumes the map header is compiled alongside.
`default_nettype none
package period_timer_pkg;
    typedef enum logic [1:0] {
        CLS_FREE,
        CLS_ONESHOT,
        CLS_MONO,
        CLS_RESERVED
    } mode_class_t;
    typedef logic [7:0] count_t;
endpackage
`default_nettype wire

//--- src/period_timer.sv
// Period timer with hardware limit, reached over classic Wishbone.
// Assumes timer_clk_i and ext_reset_signal_i are asynchronous pins and
// debug_mode_i comes from logic on clk_i.
//
// Chosen here: the register addresses and the Wishbone slave port.
`include "period_timer_map.svh"
`default_nettype none

module period_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer_clk_i,
    input wire logic ext_reset_signal_i,
    input wire logic debug_mode_i,
    output logic period_match_pulse_o,
    output logic irq_o
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic period_timer_pkg::mode_class_t class_of(
        input logic [4:0] m);
        case (m[4:3])
            2'h0: class_of = period_timer_pkg::CLS_FREE;
            2'h1: class_of = period_timer_pkg::CLS_ONESHOT;
            2'h2: class_of = period_timer_pkg::CLS_MONO;
            default: class_of = period_timer_pkg::CLS_RESERVED;
        endcase
    endfunction

    function automatic logic is_sel(input logic [2:0] low,
        input logic [2:0] code);
        is_sel = (low == code);
    endfunction

    // ************************************************************
    // Registers and state
    // ************************************************************
    period_timer_pkg::count_t count;
    period_timer_pkg::count_t period;
    logic enable;
    logic [2:0] pre_sel;
    logic [3:0] post_sel;
    logic [4:0] mode;
    logic prescale_output_sync;
    logic enable_clock_sync;
    logic flag;
    logic irq_en;
    logic run;
    logic en_sync;
    logic [6:0] pre_cnt;
    logic [3:0] post_cnt;
    logic ptick_q;
    logic tclk_s1, tclk_s2, tclk_prev;
    logic ers_s1, ers_s2, ers_hold, ers_prev;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire logic req = cyc_i & stb_i & ~ack_o;
    wire logic wr = req & we_i;
    wire logic [7:0] word_adr = {adr_i[7:2], 2'h0};
    wire logic hit_count = word_adr == `OFS_COUNT_VALUE;
    wire logic hit_period = word_adr == `OFS_PERIOD_VALUE;
    wire logic hit_ctrl = word_adr == `OFS_TIMER_CONTROL;
    wire logic hit_sts = word_adr == `OFS_MATCH_STATUS;
    wire logic wr_count = wr & hit_count & sel_i[0];
    wire logic wr_period = wr & hit_period & sel_i[0];
    wire logic wr_ctl0 = wr & hit_ctrl & sel_i[0];
    wire logic wr_ctl1 = wr & hit_ctrl & sel_i[1];
    wire logic wr_ctrl = wr_ctl0 | wr_ctl1;
    wire logic wr_sts = wr & hit_sts & sel_i[0];
    wire logic [31:0] ctrl_word = {17'h0, enable_clock_sync, prescale_output_sync, mode, post_sel,
        pre_sel, enable};
    wire logic [31:0] sts_word = {29'h0, run, irq_en, flag};
    wire logic [31:0] next_dat =
        hit_count ? {24'h0, count} :
        hit_period ? {24'h0, period} :
        hit_ctrl ? ctrl_word :
        hit_sts ? sts_word : 32'h0;

    // ************************************************************
    // Input sampling and edges
    // ************************************************************
    // Debug freezes the sampled level so no edges are seen; the held level still acts
    wire logic ers = ers_hold;
    wire logic rise = ers & ~ers_prev;
    wire logic fall = ~ers & ers_prev;
    wire logic any_edge = rise | fall;
    wire logic tedge = tclk_s2 & ~tclk_prev;

    // ************************************************************
    // Mode decode
    // ************************************************************
    period_timer_pkg::mode_class_t cls;
    assign cls = class_of(mode);
    wire logic [2:0] low = mode[2:0];
    wire logic is_free = cls == period_timer_pkg::CLS_FREE;
    wire logic is_os = cls == period_timer_pkg::CLS_ONESHOT;
    wire logic is_mono = cls == period_timer_pkg::CLS_MONO;
    wire logic mono_rsv = is_mono & (is_sel(low, 3'h0) |
        is_sel(low, 3'h4) | is_sel(low, 3'h5));
    wire logic reserved = (cls == period_timer_pkg::CLS_RESERVED) |
        mono_rsv;

    // Hardware gating and reset in free-running modes
    wire logic free_gate = is_sel(low, 3'h1) ? ers :
        is_sel(low, 3'h2) ? ~ers : 1'b1;
    wire logic free_edge_rst = (is_sel(low, 3'h3) & any_edge) |
        (is_sel(low, 3'h4) & rise) |
        (is_sel(low, 3'h5) & fall);
    wire logic free_lvl_rst = (is_sel(low, 3'h6) & ~ers) |
        (is_sel(low, 3'h7) & ers);

    // One-shot start and reset selection
    wire logic os_rise = is_sel(low, 3'h1) | is_sel(low, 3'h4) |
        is_sel(low, 3'h6);
    wire logic os_fall = is_sel(low, 3'h2) | is_sel(low, 3'h5) |
        is_sel(low, 3'h7);
    wire logic os_start = is_sel(low, 3'h0) | (os_rise & rise) |
        (os_fall & fall) | (is_sel(low, 3'h3) & any_edge);
    wire logic os_edge_rst = (is_sel(low, 3'h4) & rise) |
        (is_sel(low, 3'h5) & fall);
    wire logic os_lvl_rst = (is_sel(low, 3'h6) & ~ers) |
        (is_sel(low, 3'h7) & ers);

    // Monostable start and reset selection
    wire logic mono_start = (is_sel(low, 3'h1) & rise) |
        (is_sel(low, 3'h2) & fall) | (is_sel(low, 3'h3) & any_edge) |
        (is_sel(low, 3'h6) & ers) | (is_sel(low, 3'h7) & ~ers);
    wire logic mono_lvl_rst = (is_sel(low, 3'h6) & ~ers) |
        (is_sel(low, 3'h7) & ers);

    // ************************************************************
    // Enable, activity and reset events
    // ************************************************************
    // Timer-clock sync of enable costs one input edge but no glitches
    wire logic en_eff = enable_clock_sync ? en_sync : enable;
    // Raw enable too: a late timer-side enable must not restart a one-shot
    wire logic start_evt = enable & en_eff & ~reserved &
        (is_os ? os_start : is_mono & mono_start);
    wire logic lvl_rst = is_free ? free_lvl_rst :
        is_os ? os_lvl_rst : is_mono & mono_lvl_rst;
    wire logic ext_rst_evt = en_eff & ~reserved & ((is_free & free_edge_rst)
        | lvl_rst | (is_os & os_edge_rst));
    wire logic active = en_eff & ~reserved & ~lvl_rst &
        (is_free ? free_gate : run);
    wire logic clr_scalers = wr_count | wr_ctrl | ext_rst_evt;

    // ************************************************************
    // Prescaler
    // ************************************************************
    wire logic [6:0] pre_mask = 7'(8'hFF >> (4'h8 - {1'b0, pre_sel}));
    wire logic pre_full = (pre_cnt | ~pre_mask) == 7'h7F;
    wire logic ptick_raw = tedge & en_eff & pre_full;
    // Resync only helps when the prescaled rate is below the bus clock
    wire logic ptick = prescale_output_sync ? ptick_q : ptick_raw;
    wire logic step = ptick & active & ~clr_scalers;
    wire logic cnt_hit = count == period;
    wire logic match_evt = step & cnt_hit;

    // ************************************************************
    // Postscaler
    // ************************************************************
    wire logic [3:0] post_eff = is_os ? 4'h0 : post_sel;
    wire logic fire = match_evt & (post_cnt == post_eff);
    wire logic os_stop = match_evt & is_os;
    wire logic mono_stop = match_evt & is_mono;

    wire period_timer_pkg::count_t next_count =
        wr_count ? dat_i[7:0] :
        ext_rst_evt ? 8'h00 :
        match_evt ? 8'h00 :
        step ? count + 8'h01 : count;
    wire logic [3:0] next_post = clr_scalers ? 4'h0 :
        fire ? 4'h0 : match_evt ? post_cnt + 4'h1 : post_cnt;
    wire logic [6:0] next_pre = clr_scalers ? 7'h00 :
        (tedge & en_eff) ? pre_cnt + 7'h01 : pre_cnt;
    wire logic next_run = ~en_eff ? 1'b0 :
        (os_stop | mono_stop) ? 1'b0 :
        start_evt ? 1'b1 : run;
    wire logic next_enable = wr_ctl0 ? dat_i[`CTL_ENABLE] :
        os_stop ? 1'b0 : enable;

    // ************************************************************
    // Sampling flops
    // ************************************************************
    always_ff @(posedge clk_i) begin
        tclk_s1 <= timer_clk_i;
        tclk_s2 <= tclk_s1;
        ers_s1 <= ext_reset_signal_i;
        ers_s2 <= ers_s1;
        if (rst_i) begin
            tclk_prev <= 1'b0;
            ers_hold <= 1'b0;
            ers_prev <= 1'b0;
        end else begin
            tclk_prev <= tclk_s2;
            ers_hold <= debug_mode_i ? ers_hold : ers_s2;
            ers_prev <= ers;
        end
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            dat_o <= req ? next_dat : dat_o;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period <= `RST_PERIOD_VALUE;
            enable <= 1'b0;
            pre_sel <= `RST_PRE_SELECT;
            post_sel <= `RST_POST_SELECT;
            mode <= `RST_MODE;
            prescale_output_sync <= 1'b0;
            enable_clock_sync <= 1'b0;
            irq_en <= 1'b0;
        end else begin
            enable <= next_enable;
            if (wr_period)
                period <= dat_i[7:0];
            if (wr_ctl0) begin
                pre_sel <= dat_i[`CTL_PRE_HI:`CTL_PRE_LO];
                post_sel <= dat_i[`CTL_POST_HI:`CTL_POST_LO];
            end
            if (wr_ctl1) begin
                mode <= dat_i[`CTL_MODE_HI:`CTL_MODE_LO];
                prescale_output_sync <= dat_i[`CTL_PRESCALE_OUTPUT_SYNC];
                enable_clock_sync <= dat_i[`CTL_ENABLE_CLOCK_SYNC];
            end
            if (wr_sts)
                irq_en <= dat_i[`STS_IRQ_EN];
        end
    end

    // ************************************************************
    // Counters and outputs
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `RST_COUNT_VALUE;
            pre_cnt <= 7'h00;
            post_cnt <= 4'h0;
            ptick_q <= 1'b0;
            en_sync <= 1'b0;
            run <= 1'b0;
            flag <= 1'b0;
            period_match_pulse_o <= 1'b0;
        end else begin
            count <= next_count;
            pre_cnt <= next_pre;
            post_cnt <= next_post;
            ptick_q <= ptick_raw & ~clr_scalers;
            en_sync <= tedge ? enable : en_sync;
            run <= next_run;
            // Set wins over a same-cycle clear
            flag <= fire | (flag & ~(wr_sts & dat_i[`STS_FLAG]));
            period_match_pulse_o <= fire |
                (period_match_pulse_o & ~tedge);
        end
    end

    assign irq_o = flag & irq_en;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_reset_values;
        @(posedge clk_i) rst_i |=> (count == 8'h00 && period == 8'hFF);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("count or period wrong after reset");
    property p_match_zero;
        @(posedge clk_i) disable iff (rst_i)
        (match_evt && !wr_count) |=> count == 8'h00;
    endproperty
    a_match_zero: assert property (p_match_zero)
        else $error("count not zero after period match");
    property p_count_steps;
        @(posedge clk_i) disable iff (rst_i)
        !$stable(count) |-> (count == 8'($past(count) + 8'h01) ||
            count == 8'h00 || $past(wr_count));
    endproperty
    a_count_steps: assert property (p_count_steps)
        else $error("count moved by other than one");
    property p_ctrl_clears;
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> (pre_cnt == 7'h00 && post_cnt == 4'h0 &&
            (count == $past(count) || $past(step) || $past(ext_rst_evt)));
    endproperty
    a_ctrl_clears: assert property (p_ctrl_clears)
        else $error("control write mishandled counters");
    property p_oneshot_stop;
        @(posedge clk_i) disable iff (rst_i)
        (os_stop && !wr_ctl0) |=> (!enable && !run) [*2];
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop)
        else $error("one-shot did not stop");
    property p_mono_keeps;
        @(posedge clk_i) disable iff (rst_i)
        (mono_stop && !wr_ctl0) |=> (enable && !run && count == 8'h00);
    endproperty
    a_mono_keeps: assert property (p_mono_keeps)
        else $error("monostable lost enable or did not stop");
    property p_debug_freeze;
        @(posedge clk_i) disable iff (rst_i)
        (debug_mode_i && $past(debug_mode_i)) |-> !any_edge;
    endproperty
    a_debug_freeze: assert property (p_debug_freeze)
        else $error("external edge seen in debug");
    property p_reserved_hold;
        @(posedge clk_i) disable iff (rst_i)
        (reserved && !wr_count) |=> count == $past(count);
    endproperty
    a_reserved_hold: assert property (p_reserved_hold)
        else $error("count moved in reserved mode");
    property p_disabled_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!en_eff && !wr_count && !wr_ctrl) |=>
            (count == $past(count) && pre_cnt == $past(pre_cnt));
    endproperty
    a_disabled_hold: assert property (p_disabled_hold)
        else $error("counters moved while disabled");
    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        fire |=> (flag && period_match_pulse_o);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag or pulse missing after postscaler hit");
    property p_post_ratio;
        @(posedge clk_i) disable iff (rst_i)
        (match_evt && !fire && !clr_scalers) |=>
            post_cnt == 4'($past(post_cnt) + 4'h1);
    endproperty
    a_post_ratio: assert property (p_post_ratio)
        else $error("postscaler did not advance");
    property p_ext_clear;
        @(posedge clk_i) disable iff (rst_i)
        (ext_rst_evt && !wr_count) |=> (count == 8'h00 && pre_cnt == 7'h00);
    endproperty
    a_ext_clear: assert property (p_ext_clear)
        else $error("external reset did not clear");

    c_oneshot: cover property (@(posedge clk_i) os_stop);
    c_mono_restart: cover property (@(posedge clk_i)
        mono_stop ##[1:200] start_evt);
    c_edge_reset: cover property (@(posedge clk_i)
        is_free && free_edge_rst && en_eff);
    c_pulse: cover property (@(posedge clk_i)
        fire && post_sel != 4'h0);

endmodule // period_timer
`default_nettype wire

//--- sim/timer_far_end.sv
// Far-side model: timer clock source, trigger driver, match counter.
// Assumes the bench asks for trigger levels on clk_i.
`default_nettype none
module timer_far_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_req_i,
    input wire logic pulse_i,
    output logic tclk_o,
    output logic ext_o,
    output logic [7:0] pulses_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div;
    logic pulse_d;
    // Bench keeps each level for many ticks
    assign ext_o = ext_req_i;
    // Free-running source, eight system clocks a period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 2'h0;
            tclk_o <= 1'b0;
            pulse_d <= 1'b0;
            pulses_o <= 8'h00;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) tclk_o <= ~tclk_o;
            pulse_d <= pulse_i;
            if (pulse_i && !pulse_d) pulses_o <= pulses_o + 8'h01;
        end
    end
endmodule // timer_far_end
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the period timer over classic Wishbone.
// Assumes the register map header and the far-side model.
`include "period_timer_map.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, debug_mode_i = 1'b0, ext_req = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd, c0;
    logic ack_o, tclk, ext, pulse, irq_o;
    logic [7:0] pulses, p0;
    logic [4:0] hold_m [2] = '{5'h02, 5'h18};
    int err_total = 0, tests_run = 0, ex, d;
    always #5 clk_i = ~clk_i;
    period_timer i_period_timer (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .timer_clk_i(tclk), .ext_reset_signal_i(ext),
        .debug_mode_i(debug_mode_i), .period_match_pulse_o(pulse),
        .irq_o(irq_o));
    timer_far_end i_timer_far_end (.clk_i(clk_i), .rst_i(rst_i),
        .ext_req_i(ext_req), .pulse_i(pulse), .tclk_o(tclk),
        .ext_o(ext), .pulses_o(pulses));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] dd);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= dd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t no ack", $time);
            results();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic run(input int n);
        repeat (n * 8) @(posedge clk_i);
    endtask
    function automatic logic [31:0] ctl(input logic [4:0] m,
        input logic [2:0] pr, input logic [3:0] po, input logic en);
        return {19'h0, m, po, pr, en};
    endfunction
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        wb(0, `OFS_PERIOD_VALUE, 0); chk(rd, 32'hFF);
        wb(0, `OFS_TIMER_CONTROL, 0); chk(rd, 32'h0);
        wb(0, 8'h10, 0); chk(rd, 32'h0);
        wb(1, `OFS_PERIOD_VALUE, 32'h3);
        for (int i = 0; i < 6; i++) begin
            wb(1, `OFS_COUNT_VALUE, 0);
            p0 = pulses;
            // Sync options on the slow prescaled cases only
            wb(1, `OFS_TIMER_CONTROL, ctl(5'h00, i / 2, i % 2, 1)
                | (i > 3 ? 32'h6000 : 32'h0));
            run(64);
            wb(1, `OFS_TIMER_CONTROL, 0);
            ex = 16 >> (i / 2 + i % 2);
            d = int'(pulses - p0);
            chk({31'h0, d >= ex - 1 && d <= ex + 1}, 1);
        end
        wb(0, `OFS_MATCH_STATUS, 0); chk(rd & 32'h1, 32'h1);
        chk({31'h0, irq_o}, 0);
        wb(1, `OFS_MATCH_STATUS, 32'h3);
        wb(0, `OFS_MATCH_STATUS, 0); chk(rd, 32'h2);
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h00, 0, 0, 1));
        run(8); chk({31'h0, irq_o}, 1);
        wb(1, `OFS_TIMER_CONTROL, 0);
        wb(0, `OFS_COUNT_VALUE, 0);
        c0 = rd;
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, c0);
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h00, 3, 2, 0));
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, c0);
        wb(1, `OFS_COUNT_VALUE, 32'h2);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h2);
        wb(1, `OFS_PERIOD_VALUE, 32'h2);
        wb(1, `OFS_COUNT_VALUE, 0);
        p0 = pulses;
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h08, 0, 3, 1));
        run(30);
        wb(0, `OFS_TIMER_CONTROL, 0); chk(rd & 32'h1, 32'h0);
        chk({24'h0, pulses - p0}, 1);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        // Monostable, rising edge start: no edge yet
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h11, 0, 0, 1));
        run(10);
        p0 = pulses;
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        ext_req <= 1'b1;
        run(20); chk({24'h0, pulses - p0}, 1);
        wb(0, `OFS_TIMER_CONTROL, 0); chk(rd & 32'h1, 32'h1);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        ext_req <= 1'b0;
        run(8);
        ext_req <= 1'b1;
        run(20); chk({24'h0, pulses - p0}, 2);
        wb(1, `OFS_PERIOD_VALUE, 32'hFF);
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h07, 0, 0, 1));
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        debug_mode_i <= 1'b1;
        run(1);
        ext_req <= 1'b0;
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0); chk(rd, 32'h0);
        debug_mode_i <= 1'b0;
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0); chk({31'h0, rd != 32'h0}, 1);
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h04, 0, 0, 1));
        run(20);
        ext_req <= 1'b1;
        run(2);
        wb(0, `OFS_COUNT_VALUE, 0); chk({31'h0, rd < 32'h5}, 1);
        for (int i = 0; i < 2; i++) begin
            wb(1, `OFS_TIMER_CONTROL, ctl(hold_m[i], 0, 0, 1));
            wb(0, `OFS_COUNT_VALUE, 0);
            c0 = rd;
            run(10);
            wb(0, `OFS_COUNT_VALUE, 0); chk(rd, c0);
        end
        // One-shot, rising edge start and rising edge reset
        wb(1, `OFS_COUNT_VALUE, 32'h80);
        wb(1, `OFS_TIMER_CONTROL, ctl(5'h0C, 0, 0, 1));
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0);
        chk(rd, 32'h80);
        ext_req <= 1'b0;
        run(8);
        ext_req <= 1'b1;
        run(10);
        wb(0, `OFS_COUNT_VALUE, 0);
        chk({31'h0, rd > 32'h0 && rd < 32'h20}, 1);
        wb(0, `OFS_MATCH_STATUS, 0);
        chk(rd & 32'h4, 32'h4);
        ext_req <= 1'b0;
        run(8);
        ext_req <= 1'b1;
        run(2);
        wb(0, `OFS_COUNT_VALUE, 0);
        chk({31'h0, rd < 32'h5}, 1);
        results();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        results();
    end
endmodule // tb_top
`default_nettype wire
